// ==== hw/rsq_pkg.sv ====
// constants shared by the reset initialisation sequencer
// assumes one 25 MHz system clock drives all of the sequencer logic
//
// What this block relies on and does
// R01 - primary clock is system clock input in host mode, pci sync clock in agent
// R02 - host mode: board holds power-on reset for 32 stable system clock periods
// R03 - agent mode: board holds power-on reset for 32 stable pci sync periods
// R04 - outside agent holds hard reset input low 32 pci sync periods to reset
// R05 - device drives hard reset output for at least 512 pci sync periods
// R06 - board sets straps valid 4 primary periods before power-on reset negates
// R07 - board holds straps until hard reset negates; zero hold after that
// R08 - device releases strap-shared pins within 4 ns of hard reset assertion; code drives them until an outside one has lasted 32 pci periods
// R09 - device re-drives strap-shared pins at least 1 pci period after hard reset
// R10 - power-on configuration is a 4-bit reset source plus a clock-divide strap
// R11 - host mode derives pci sync period from system clock by the divide strap
// R12 - device allows up to 100 us for every pll to lock
// R13 - core reset and hard reset stay asserted until plls lock or wait expires
package rsq_pkg;

    localparam int CLK_MHZ      = 25;
    localparam int PLL_LOCK_US  = 100;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int NUM_PLL      = 4;

    localparam logic [5:0]  POR_MIN   = 6'h20;
    localparam logic [5:0]  EXT_LAST  = 6'h1F;
    localparam logic [9:0]  HRST_LAST = 10'h1FF;
    localparam logic [11:0] PLL_LAST  = 12'(PLL_LOCK_CYC - 1);

    // positions in the synchronised pin vector
    localparam int SY_SYS   = 0;
    localparam int SY_PCI   = 1;
    localparam int SY_POR   = 2;
    localparam int SY_HRST  = 3;
    localparam int SY_AGENT = 4;
    localparam int SY_DIV   = 5;
    localparam int SY_SRC   = 6;
    localparam int SY_PLL   = 10;
    localparam int SY_W     = 14;

    typedef enum logic [2:0] {
        ST_POR  = 3'h0,
        ST_PLLW = 3'h1,
        ST_HDRV = 3'h3,
        ST_GAP  = 3'h2,
        ST_RUN  = 3'h6
    } rsq_state_t;

endpackage

// ==== hw/rsq_sync.sv ====
// two-flop synchroniser with rising-edge detect for a vector of pins
// assumes every bit is unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none
module rsq_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    // the edge detector looks only at the second and third stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise  = sync_q & ~last_q;
endmodule
`default_nettype wire

// ==== hw/rsq_reset_seq.sv ====
// reset initialisation sequencer: clock choice, reset qualification, straps, pll wait
// assumes pin clocks are far slower than I_CLK_SYS so that they can be sampled
`timescale 1ns/1ps
`default_nettype none
module rsq_reset_seq
    import rsq_pkg::*;
(
    input  wire logic               I_CLK_SYS,
    input  wire logic               I_RESETN,
    input  wire logic               I_SYSTEM_CLOCK_INPUT,
    input  wire logic               I_PCI_SYNC_CLK,
    input  wire logic               I_POWER_ON_RESET_N,
    input  wire logic               I_HARD_RESET_N,
    input  wire logic               I_PCI_AGENT_MODE,
    input  wire logic               I_CLOCK_DIVIDE_STRAP,
    input  wire logic [0:3]         I_RESET_SOURCE,
    input  wire logic [NUM_PLL-1:0] I_PLL_LOCK,
    output logic                    O_HARD_RESET_N,
    output logic                    O_HARD_RESET_OE,
    output logic                    O_SHARED_PIN_OE,
    output logic                    O_CORE_RESET_N,
    output logic                    O_PRIMARY_IS_PCI,
    output logic [0:3]              O_RESET_SOURCE,
    output logic                    O_CLOCK_DIVIDE
);
    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [SY_W-1:0] raw;
    logic [SY_W-1:0] lvl;
    logic [SY_W-1:0] rise;

    assign raw = {I_PLL_LOCK, I_RESET_SOURCE, I_CLOCK_DIVIDE_STRAP, I_PCI_AGENT_MODE,
                  I_HARD_RESET_N, I_POWER_ON_RESET_N, I_PCI_SYNC_CLK, I_SYSTEM_CLOCK_INPUT};

    rsq_sync #(
        .W (SY_W)
    ) u_sync (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RESETN),
        .i_async (raw),
        .o_level (lvl),
        .o_rise  (rise)
    );

    logic agent_s;
    logic por_s;
    logic hrst_in_s;
    logic all_lock;

    assign agent_s   = lvl[SY_AGENT];
    assign por_s     = lvl[SY_POR];
    assign hrst_in_s = lvl[SY_HRST];
    assign all_lock  = &lvl[SY_PLL +: NUM_PLL];

    // ------------------------------------------------------------------
    // clock ticks
    // ------------------------------------------------------------------
    logic prim_tick;
    logic pci_tick;
    logic half_q;

    assign prim_tick = agent_s ? rise[SY_PCI] : rise[SY_SYS]; // R01
    // host mode divides the system clock by two when the strap is set
    assign pci_tick  = agent_s ? rise[SY_PCI]
                               : (rise[SY_SYS] && (!O_CLOCK_DIVIDE || half_q)); // R11

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            half_q <= 1'b0;
        end else if (rise[SY_SYS]) begin
            half_q <= ~half_q;
        end
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    rsq_state_t  st_q;
    rsq_state_t  st_d;
    logic [5:0]  por_cnt_q;
    logic [5:0]  ext_cnt_q;
    logic [9:0]  hcnt_q;
    logic [11:0] pll_cnt_q;
    logic        por_ok;

    // hard reset is driven in every state up to its release edge
    function automatic logic drives_hrst(input rsq_state_t s);
        return (s == ST_POR || s == ST_PLLW || s == ST_HDRV);
    endfunction

    assign por_ok = (por_cnt_q == POR_MIN);

    always_comb begin
        st_d = st_q;
        if (!por_s) begin
            st_d = ST_POR;
        end else begin
            case (st_q)
                ST_POR: begin
                    if (por_ok) begin
                        st_d = ST_PLLW;
                    end
                end
                ST_PLLW: begin
                    if (all_lock || pll_cnt_q == PLL_LAST) begin // R12 R13
                        st_d = ST_HDRV;
                    end
                end
                ST_HDRV: begin
                    if (pci_tick && hcnt_q == HRST_LAST) begin // R05
                        st_d = ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (pci_tick) begin // R09
                        st_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!hrst_in_s && pci_tick && ext_cnt_q == EXT_LAST) begin // R04
                        st_d = ST_HDRV;
                    end
                end
                default: begin
                    st_d = ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_q <= ST_POR;
        end else begin
            st_q <= st_d;
        end
    end

    // a short power-on pulse restarts the count; the board owns the minimum
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            por_cnt_q <= '0;
        end else if (por_s) begin
            por_cnt_q <= '0;
        end else if (prim_tick && !por_ok) begin
            por_cnt_q <= por_cnt_q + 6'h01; // R02 R03
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ext_cnt_q <= '0;
        end else if (st_q != ST_RUN || hrst_in_s) begin
            ext_cnt_q <= '0;
        end else if (pci_tick && ext_cnt_q != EXT_LAST) begin
            ext_cnt_q <= ext_cnt_q + 6'h01; // R04
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hcnt_q <= '0;
        end else if (st_q != ST_HDRV) begin
            hcnt_q <= '0;
        end else if (pci_tick) begin
            hcnt_q <= hcnt_q + 10'h001; // R05
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pll_cnt_q <= '0;
        end else if (st_q != ST_PLLW) begin
            pll_cnt_q <= '0;
        end else begin
            pll_cnt_q <= pll_cnt_q + 12'h001; // R12
        end
    end

    // ------------------------------------------------------------------
    // straps and outputs
    // ------------------------------------------------------------------
    // straps are caught on the edge that qualifies power-on reset negation
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RESET_SOURCE <= 4'h0;
            O_CLOCK_DIVIDE <= 1'b0;
        end else if (st_q == ST_POR && st_d == ST_PLLW) begin
            O_RESET_SOURCE <= lvl[SY_SRC +: 4]; // R10
            O_CLOCK_DIVIDE <= lvl[SY_DIV]; // R10
        end
    end

    // the reset outputs follow st_d so the pin release lands on the same edge as the
    // hard reset drive; an outside hard reset is only seen after the synchroniser
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_HARD_RESET_N   <= 1'b0;
            O_HARD_RESET_OE  <= 1'b1;
            O_SHARED_PIN_OE  <= 1'b0;
            O_CORE_RESET_N   <= 1'b0;
            O_PRIMARY_IS_PCI <= 1'b0;
        end else begin
            O_HARD_RESET_N   <= !drives_hrst(st_d); // R13
            O_HARD_RESET_OE  <= drives_hrst(st_d);
            O_SHARED_PIN_OE  <= (st_d == ST_RUN); // R08 R09
            O_CORE_RESET_N   <= (st_d == ST_RUN); // R13
            O_PRIMARY_IS_PCI <= agent_s; // R01
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_HRST_MIN: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R05
        $rose(O_HARD_RESET_N) |-> $past(hcnt_q) == HRST_LAST)
        else $error("hard reset released before 512 pci periods");

    AST_PIN_OFF: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R08
        O_HARD_RESET_OE |-> !O_SHARED_PIN_OE)
        else $error("shared pins driven during hard reset");

    AST_PIN_GAP: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R09
        $rose(O_SHARED_PIN_OE) |-> $past(O_HARD_RESET_N) && $past(O_HARD_RESET_N, 2))
        else $error("shared pins re-driven too soon");

    AST_PRIM_SEL: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R01
        agent_s |=> O_PRIMARY_IS_PCI)
        else $error("primary clock choice does not follow mode");

    AST_STRAP_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R10
        (st_q != ST_POR) |=> $stable(O_RESET_SOURCE) && $stable(O_CLOCK_DIVIDE))
        else $error("strap values changed outside power-on reset");

    AST_PLL_TIMEOUT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R12
        (st_q == ST_PLLW && pll_cnt_q == PLL_LAST && por_s) |=> st_q == ST_HDRV)
        else $error("pll wait overran its limit");

    AST_CORE_HELD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R13
        !O_HARD_RESET_N |-> !O_CORE_RESET_N)
        else $error("core released while hard reset asserted");

    AST_DIV_TICK: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) // R11
        (!agent_s && O_CLOCK_DIVIDE && pci_tick) |=> !half_q && (!pci_tick || agent_s))
        else $error("divided pci tick is not every second system edge");
endmodule
`default_nettype wire

// ==== test/rsq_board.sv ====
// board model: free-running pin clocks and the pulled-up hard reset wire
// assumes it is clocked by the bench's system clock
`timescale 1ns/1ps
`default_nettype none
module rsq_board (
    input  wire logic i_clk,
    input  wire logic i_dev_val,
    input  wire logic i_dev_oe,
    input  wire logic i_ext_low,
    output logic      o_sys_pin,
    output logic      o_pci_pin,
    output wire logic o_hrst_pin
);
    logic [3:0] div_q;

    initial begin
        div_q     = 4'h0;
        o_sys_pin = 1'b0;
        o_pci_pin = 1'b0;
    end

    // clocks never pause, so each reset hold sees a stable clock
    always @(negedge i_clk) begin
        div_q <= (div_q == 4'hB) ? 4'h0 : div_q + 4'h1;
        if (div_q[1:0] == 2'h3) o_sys_pin <= ~o_sys_pin;
        if (div_q == 4'h5 || div_q == 4'hB) o_pci_pin <= ~o_pci_pin;
    end

    // pull-up: high unless the device or the outside agent pulls it low
    assign o_hrst_pin = ~((i_dev_oe & ~i_dev_val) | i_ext_low);
endmodule
`default_nettype wire

// ==== test/rsq_reset_seq_tb.sv ====
// self-checking bench for the reset initialisation sequencer
// assumes rsq_board supplies the pin clocks: sys period 8, pci period 12
`timescale 1ns/1ps
`default_nettype none
module rsq_reset_seq_tb;
    import rsq_pkg::*;
    logic               clk, rst_n, por_n, agent, dv, ext_low;
    logic [0:3]         src, src_q;
    logic [NUM_PLL-1:0] lock;
    logic               sys_pin, pci_pin, hr_pin, hr_n, hr_oe, sh_oe, core_n, prim, div_q;
    int                 mismatches, n_compared;

    rsq_board board (.i_clk(clk), .i_dev_val(hr_n), .i_dev_oe(hr_oe), .i_ext_low(ext_low),
        .o_sys_pin(sys_pin), .o_pci_pin(pci_pin), .o_hrst_pin(hr_pin));

    rsq_reset_seq dut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_SYSTEM_CLOCK_INPUT(sys_pin),
        .I_PCI_SYNC_CLK(pci_pin), .I_POWER_ON_RESET_N(por_n), .I_HARD_RESET_N(hr_pin),
        .I_PCI_AGENT_MODE(agent), .I_CLOCK_DIVIDE_STRAP(dv), .I_RESET_SOURCE(src),
        .I_PLL_LOCK(lock), .O_HARD_RESET_N(hr_n), .O_HARD_RESET_OE(hr_oe),
        .O_SHARED_PIN_OE(sh_oe), .O_CORE_RESET_N(core_n), .O_PRIMARY_IS_PCI(prim),
        .O_RESET_SOURCE(src_q), .O_CLOCK_DIVIDE(div_q));

    always #20 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // cycle counts are the bench's own, so a plain int range is enough
    task automatic check_in(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_high(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1) begin
            if (n == 20000) begin
                mismatches++;
                complete_run();
            end
            cyc(1);
            n++;
        end
    endtask

    // hard reset release, then pins and core one pci sync period later
    task automatic finish_drive(input int p, input int lo, input int hi);
        int n;
        wait_high(hr_n, n);
        check_in(n, lo, hi);
        check({hr_oe, sh_oe, core_n}, 8'h00);
        wait_high(sh_oe, n);
        check_in(n, p - 1, p + 1);
        check(core_n, 8'h01);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic por_short();
        src   = 4'hF;
        lock  = '1;
        por_n = 1'b0;
        cyc(20 * 8);
        por_n = 1'b1;
        cyc(300);
        check({src_q, core_n, hr_oe}, {2'h0, 4'h0, 2'h1});
    endtask

    task automatic boot(input logic ag, input logic d, input logic [0:3] s,
                        input logic lk, input int p, input int w);
        por_n = 1'b0;
        agent = ag;
        dv    = d;
        src   = s;
        lock  = '0;
        cyc(4);
        check({hr_n, hr_oe, sh_oe, core_n}, 8'h04);
        cyc(40 * p);
        lock  = {NUM_PLL{lk}};
        por_n = 1'b1;
        finish_drive(p, 511 * p + w - 2, 512 * p + w + 4);
        check({src_q, div_q, prim}, {2'h0, s, d, ag});
        src = ~s;
        dv  = ~d;
        cyc(8);
        check({src_q, div_q}, {3'h0, s, d});
    endtask

    task automatic ext_reset();
        int n;
        ext_low = 1'b1;
        cyc(20 * 12);
        check(core_n, 8'h01);
        ext_low = 1'b0;
        cyc(8);
        ext_low = 1'b1;
        wait_high(hr_oe, n);
        check_in(n, 31 * 12, 32 * 12 + 6);
        check({hr_n, sh_oe, core_n}, 8'h00);
        ext_low = 1'b0;
        finish_drive(12, 512 * 12 - 2, 512 * 12 + 2);
    endtask

    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        por_n      = 1'b0;
        agent      = 1'b0;
        dv         = 1'b0;
        ext_low    = 1'b0;
        src        = 4'h0;
        lock       = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        por_short();
        boot(1'b1, 1'b0, 4'hA, 1'b1, 12, 4);
        ext_reset();
        boot(1'b0, 1'b0, 4'h5, 1'b1, 8, 4);
        boot(1'b0, 1'b1, 4'hC, 1'b1, 16, 4);
        boot(1'b1, 1'b0, 4'h3, 1'b0, 12, PLL_LOCK_CYC + 2);
        complete_run();
    end
endmodule
`default_nettype wire
